// ---- rtl/in_endpoint_regs.vh ----
`ifndef IN_ENDPOINT_REGS_VH
`define IN_ENDPOINT_REGS_VH
`define ADDR_CONTROL    3'h0
`define ADDR_STATUS     3'h1
`define ADDR_BYTE_COUNT 3'h2
`define ADDR_FIFO_FLAGS 3'h3
`define ADDR_IRQ_STATUS 3'h4
`define ADDR_IRQ_ENABLE 3'h5
`define ADDR_IRQ_CLEAR  3'h6
`define BIT_ENABLE      0
`define BIT_ARMED       1
`define BIT_STALL       3
`define BIT_PERMIT      6
`define BIT_CLEAR       7
`define BIT_ACK         0
`define BIT_NACKED      2
`define BIT_STALLED     3
`define BIT_TOGGLE      7
`define BIT_EMPTY       3
`define BIT_OVERRUN     0
`define BIT_UNDERRUN    1
`define CONTROL_MASK    8'hcb
`define CONTROL_RESET   8'h00
`define FLAGS_RESET     8'h08
`define CLEAR_CYCLES    2'h2
`define HS_NONE         2'h0
`define HS_DATA         2'h1
`define HS_NACK         2'h2
`define HS_STALL        2'h3
`endif

// ---- rtl/fifo_clear_seq.v ----
`timescale 1ns/10ps
`include "in_endpoint_regs.vh"
module fifo_clear_seq (
  input  wire clk,        // device clock
  input  wire resetn,     // async reset, active low
  input  wire start,      // clear requested this cycle
  output reg  pointerRst, // fifo pointer reset pulse
  output reg  done        // one cycle pulse at end of reset
);
  reg [1:0] countReg;
  // hold pointer reset for a fixed count, then report completion
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      countReg   <= 2'h0;
      pointerRst <= 1'b0;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && countReg == 2'h0) begin
        countReg   <= `CLEAR_CYCLES;
        pointerRst <= 1'b1;
      end else if (countReg != 2'h0) begin
        countReg <= countReg - 2'h1;
        if (countReg == 2'h1) begin
          pointerRst <= 1'b0;
          done       <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- rtl/in_reply_select.v ----
`timescale 1ns/10ps
`include "in_endpoint_regs.vh"
module in_reply_select (
  input  wire       enable, // endpoint enabled
  input  wire       armed,  // fifo armed
  input  wire       stall,  // stall requested
  output reg  [1:0] reply   // handshake choice
);
  // choose the answer for a valid in transaction
  always @* begin
    if (!enable)
      reply = `HS_NONE;
    else if (stall)
      reply = `HS_STALL;
    else if (armed)
      reply = `HS_DATA;
    else
      reply = `HS_NACK;
  end
endmodule

// ---- rtl/in_endpoint_tx_control.v ----
`timescale 1ns/10ps
`include "in_endpoint_regs.vh"
module in_endpoint_tx_control (
  input  wire       clk,          // 50 MHz device clock
  input  wire       resetn,       // async power-on reset, active low
  input  wire [2:0] addr,         // register address
  input  wire [7:0] wrData,       // write data
  input  wire       wrEn,         // write strobe
  input  wire       rdEn,         // read strobe
  output reg  [7:0] rdData,       // read data, cycle after strobe
  input  wire       inToken,      // valid in transaction pulse
  input  wire       hostAck,      // host acknowledged our data pulse
  input  wire       fifoOverrun,  // fifo over-run event pulse
  input  wire       fifoUnderrun, // fifo under-run event pulse
  input  wire       fifoEmpty,    // live fifo empty level
  output reg  [1:0] reply,        // handshake chosen, valid with replyValid
  output reg        replyValid,   // one cycle pulse per in transaction while the endpoint is enabled
  output reg        dataPid1,     // data1 pid when high
  output reg  [3:0] byteCount,    // bytes to send
  output reg        pointerReset, // fifo pointer reset level
  output reg        irq           // level interrupt
);
  reg  [7:0] controlReg;
  reg  [7:0] statusReg;
  reg  [3:0] countReg;
  reg  [7:0] flagsReg;
  reg  [1:0] irqStatusReg;
  reg  [1:0] irqEnableReg;
  wire       clearStart;
  wire       clearDone;
  wire       ptrRst;
  wire [1:0] replyNext;
  wire       ackSet;
  wire       wrCtl;
  wire       wrSts;

  function sel;
    input [2:0] a;
    input [2:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  assign wrCtl      = wrEn && sel(addr, `ADDR_CONTROL);
  assign wrSts      = wrEn && sel(addr, `ADDR_STATUS);
  assign clearStart = wrCtl && wrData[`BIT_CLEAR];
  assign ackSet     = inToken && replyNext == `HS_DATA && hostAck;

  fifo_clear_seq clearSeq (
    .clk        (clk),
    .resetn     (resetn),
    .start      (clearStart),
    .pointerRst (ptrRst),
    .done       (clearDone)
  );

  in_reply_select replySel (
    .enable (controlReg[`BIT_ENABLE]),
    .armed  (controlReg[`BIT_ARMED]),
    .stall  (controlReg[`BIT_STALL]),
    .reply  (replyNext)
  );

  // control register; reserved bits held at zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      controlReg <= `CONTROL_RESET;
    end else begin
      if (wrCtl)
        controlReg <= wrData & `CONTROL_MASK;
      if (ackSet)
        controlReg[`BIT_ARMED] <= 1'b0;
      // a byte count write beside an acknowledge re-arms: set wins over clear
      if (wrEn && sel(addr, `ADDR_BYTE_COUNT))
        controlReg[`BIT_ARMED] <= 1'b1;
      if (clearStart)
        controlReg[`BIT_ARMED] <= 1'b0;
      if (clearDone)
        controlReg[`BIT_CLEAR] <= 1'b0;
    end
  end

  // status register: toggle, stall, nack, ack
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      statusReg <= 8'h00;
    end else begin
      if (wrSts) begin
        if (controlReg[`BIT_PERMIT])
          statusReg[`BIT_TOGGLE] <= wrData[`BIT_TOGGLE];
        if (!wrData[`BIT_ACK])
          statusReg[`BIT_ACK] <= 1'b0;
      end
      if (inToken && replyNext != `HS_NONE) begin
        statusReg[`BIT_STALLED] <= (replyNext == `HS_STALL);
        statusReg[`BIT_NACKED]  <= (replyNext == `HS_NACK);
      end
      if (ackSet) begin
        statusReg[`BIT_ACK]    <= 1'b1;
        statusReg[`BIT_TOGGLE] <= ~statusReg[`BIT_TOGGLE];
      end
    end
  end

  // byte count register
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      countReg <= 4'h0;
    else if (wrEn && sel(addr, `ADDR_BYTE_COUNT))
      countReg <= wrData[3:0];
  end

  // fifo flags: sticky over/under-run, empty mirrors fifo
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flagsReg <= `FLAGS_RESET;
    end else begin
      if (clearDone)
        flagsReg <= `FLAGS_RESET;
      else
        flagsReg[`BIT_EMPTY] <= fifoEmpty;
      // an error in the completion cycle is kept, not lost to the reset
      if (fifoOverrun)
        flagsReg[`BIT_OVERRUN] <= 1'b1;
      if (fifoUnderrun)
        flagsReg[`BIT_UNDERRUN] <= 1'b1;
    end
  end

  // interrupt status: bit0 ack, bit1 fifo error; set wins over clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqStatusReg <= 2'h0;
      irqEnableReg <= 2'h0;
    end else begin
      if (wrEn && sel(addr, `ADDR_IRQ_ENABLE))
        irqEnableReg <= wrData[1:0];
      irqStatusReg <= ((wrEn && sel(addr, `ADDR_IRQ_CLEAR)) ?
                       (irqStatusReg & ~wrData[1:0]) : irqStatusReg)
                      | {fifoOverrun | fifoUnderrun, ackSet};
    end
  end

  // registered outputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData       <= 8'h00;
      reply        <= `HS_NONE;
      replyValid   <= 1'b0;
      dataPid1     <= 1'b0;
      byteCount    <= 4'h0;
      pointerReset <= 1'b0;
      irq          <= 1'b0;
    end else begin
      replyValid   <= inToken && replyNext != `HS_NONE;
      reply        <= inToken ? replyNext : `HS_NONE;
      dataPid1     <= statusReg[`BIT_TOGGLE];
      byteCount    <= countReg;
      pointerReset <= ptrRst;
      irq          <= |(irqStatusReg & irqEnableReg);
      rdData       <= 8'h00;
      if (rdEn) begin
        case (addr)
          `ADDR_CONTROL:    rdData <= controlReg;
          `ADDR_STATUS:     rdData <= statusReg;
          `ADDR_BYTE_COUNT: rdData <= {4'h0, countReg};
          `ADDR_FIFO_FLAGS: rdData <= flagsReg;
          `ADDR_IRQ_STATUS: rdData <= {6'h00, irqStatusReg};
          `ADDR_IRQ_ENABLE: rdData <= {6'h00, irqEnableReg};
          default:          rdData <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ---- tb/host_side_model.sv ----
`timescale 1ns/10ps
module host_side_model (
  input  wire clk,     // device clock
  input  wire go,      // issue one in transaction
  input  wire ackIt,   // host accepts the data packet
  output reg  inToken, // valid in transaction pulse
  output reg  hostAck  // host ack level
);
  initial begin
    inToken = 1'b0;
    hostAck = 1'b0;
  end
  // one-cycle token; ack means nothing outside it, so it wanders
  always @(posedge clk) begin
    inToken <= go;
    hostAck <= go ? ackIt : ~hostAck;
  end
endmodule

// ---- tb/in_endpoint_tx_control_asserts.sv ----
`timescale 1ns/10ps
`include "in_endpoint_regs.vh"
module in_endpoint_tx_control_asserts (
  input wire       clk,          // clock
  input wire       resetn,       // reset
  input wire [2:0] addr,         // address
  input wire [7:0] wrData,       // write data
  input wire       wrEn,         // write strobe
  input wire       rdEn,         // read strobe
  input wire [7:0] rdData,       // read data
  input wire       inToken,      // in transaction
  input wire       hostAck,      // host ack
  input wire [1:0] reply,        // handshake
  input wire       replyValid,   // handshake valid
  input wire       dataPid1,     // toggle
  input wire       pointerReset  // fifo reset
);
  wire clrWr;
  // write of one to the clear bit
  assign clrWr = wrEn && addr == `ADDR_CONTROL && wrData[`BIT_CLEAR];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_reply_cause: assert property (replyValid |-> $past(inToken))
    else $error("reply without in transaction");
  chk_reply_code: assert property (replyValid |-> reply != `HS_NONE)
    else $error("reply carries no handshake");
  chk_pid_flip: assert property (replyValid && reply == `HS_DATA && $past(hostAck)
    && !$past(wrEn) |=> $changed(dataPid1)) else $error("toggle kept after ack");
  chk_pid_hold: assert property (replyValid && !(reply == `HS_DATA && $past(hostAck))
    && !$past(wrEn) |=> $stable(dataPid1)) else $error("toggle moved without ack");
  chk_clear_ptr: assert property (clrWr |-> ##[1:3] pointerReset)
    else $error("clear did not reset pointers");
  chk_ptr_ends: assert property ($rose(pointerReset) |-> ##[1:4] !pointerReset)
    else $error("pointer reset stuck");
  chk_ptr_cause: assert property ($rose(pointerReset) |->
    $past(clrWr) || $past(clrWr, 2) || $past(clrWr, 3)) else $error("spurious reset");
  chk_read_idle: assert property (!$past(rdEn) |-> rdData == 8'h00)
    else $error("read data outside slot");
  cover property (replyValid && reply == `HS_STALL);
  cover property (replyValid && reply == `HS_DATA);
  cover property ($rose(pointerReset));
endmodule
bind in_endpoint_tx_control in_endpoint_tx_control_asserts u_chk (.clk, .resetn, .addr,
  .wrData, .wrEn, .rdEn, .rdData, .inToken, .hostAck, .reply, .replyValid, .dataPid1,
  .pointerReset);

// ---- tb/in_endpoint_tx_control_bench.sv ----
`timescale 1ns/10ps
module in_endpoint_tx_control_bench;
  reg        clk, resetn, wrEn, rdEn, fifoOverrun, fifoUnderrun, fifoEmpty, go, ackIt;
  reg  [2:0] addr;
  reg  [7:0] wrData;
  wire [7:0] rdData;
  wire [3:0] byteCount;
  wire [1:0] reply;
  wire       replyValid, dataPid1, pointerReset, irq, inToken, hostAck;
  integer    nFail, nCompared;
  in_endpoint_tx_control dut (.clk, .resetn, .addr, .wrData, .wrEn, .rdEn, .rdData, .inToken,
    .hostAck, .fifoOverrun, .fifoUnderrun, .fifoEmpty, .reply, .replyValid, .dataPid1,
    .byteCount, .pointerReset, .irq);
  host_side_model host (.clk, .go, .ackIt, .inToken, .hostAck);
  // clock of 20 ns
  always #10 clk = ~clk;
  task chk(input [7:0] g, input [7:0] e);
    begin
      nCompared = nCompared + 1;
      if (g !== e) begin
        nFail = nFail + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      addr <= a; wrData <= d; wrEn <= 1'b1; @(posedge clk);
      wrEn <= 1'b0; @(posedge clk);
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [2:0] a, input [7:0] e);
    begin
      addr <= a; rdEn <= 1'b1; @(posedge clk);
      rdEn <= 1'b0; #1 chk(rdData, e); @(posedge clk);
    end
  endtask
  // pins {pid, pointer reset, 0, irq, count}, looked at once settled after the edge
  task chkPins(input [7:0] e);
    begin
      #1 chk({dataPid1, pointerReset, 1'b0, irq, byteCount}, e); @(posedge clk);
    end
  endtask
  // one in transaction; expect 0 none, 5 data, 6 nack, 7 stall
  task tx(input ack, input [7:0] e);
    begin
      go <= 1'b1; ackIt <= ack; @(posedge clk);
      go <= 1'b0; @(posedge clk);
      #1 chk({5'h0, replyValid, replyValid ? reply : 2'h0}, e); @(posedge clk);
    end
  endtask
  task report_and_stop;
    begin
      $display("compared=%0d failed=%0d", nCompared, nFail);
      if (nFail == 0 && nCompared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // watchdog well past the test length
  initial begin
    repeat (3000) @(posedge clk);
    nFail = nFail + 1;
    report_and_stop;
  end
  // main sequence
  initial begin
    {clk, resetn, wrEn, rdEn, fifoOverrun, fifoUnderrun, go, ackIt} = 8'h00;
    fifoEmpty = 1'b1; addr = 3'h0; wrData = 8'h00; nFail = 0; nCompared = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1; @(posedge clk);
    rd(3'h0, 8'h00);
    rd(3'h3, 8'h08);
    wr(3'h0, 8'h7f); rd(3'h0, 8'h4b);
    tx(1'b1, 8'h07);
    wr(3'h0, 8'h01); tx(1'b1, 8'h06);
    wr(3'h0, 8'h09); tx(1'b1, 8'h07);
    wr(3'h0, 8'h00); tx(1'b1, 8'h00);
    wr(3'h0, 8'h01); wr(3'h5, 8'h01); wr(3'h2, 8'h05);
    rd(3'h0, 8'h03);
    rd(3'h2, 8'h05);
    tx(1'b1, 8'h05);
    chkPins(8'h95);
    rd(3'h1, 8'h81);
    rd(3'h0, 8'h01);
    wr(3'h5, 8'h00); chkPins(8'h85);
    wr(3'h5, 8'h01); wr(3'h6, 8'h01); chkPins(8'h85);
    wr(3'h1, 8'h00); rd(3'h1, 8'h80);
    wr(3'h0, 8'h41); wr(3'h1, 8'h00); rd(3'h1, 8'h00);
    wr(3'h2, 8'h03); fifoOverrun <= 1'b1; fifoUnderrun <= 1'b1; @(posedge clk);
    fifoOverrun <= 1'b0; fifoUnderrun <= 1'b0; rd(3'h3, 8'h0b);
    rd(3'h4, 8'h02);
    wr(3'h0, 8'h81); chkPins(8'h43);
    repeat (2) @(posedge clk);
    rd(3'h0, 8'h01);
    rd(3'h3, 8'h08);
    report_and_stop;
  end
endmodule
